//--- core/iap_pkg.sv
// Shared constants for the interrupt accept prioritizer
package iap_pkg;

  // Source groups: one control register each
  localparam int          IAP_NGRP    = 7;
  localparam int          IAP_NEXT    = 5;              // External request pins
  localparam int          IAP_NPER    = 5;              // Peripheral request lines
  localparam logic [2:0]  IAP_G_TMR   = 3'h0;           // All timers
  localparam logic [2:0]  IAP_G_SER   = 3'h1;           // Serial receive and transmit
  localparam int          IAP_G_EXT0  = 2;              // First external pin group

  // Register offsets
  localparam logic [7:0]  IAP_OFS_EOI    = 8'h02;
  localparam logic [7:0]  IAP_OFS_MASK   = 8'h08;
  localparam logic [7:0]  IAP_OFS_PLIM   = 8'h0a;
  localparam logic [7:0]  IAP_OFS_INSERV = 8'h0c;
  localparam logic [7:0]  IAP_OFS_REQST  = 8'h0e;
  localparam logic [7:0]  IAP_OFS_STATUS = 8'h10;
  localparam logic [7:0]  IAP_OFS_CTL0   = 8'h12;       // Group g at CTL0 + 2*g
  localparam logic [7:0]  IAP_CTL_STRIDE = 8'h02;

  // Control register fields
  localparam int          IAP_CTL_PRIO_LSB = 0;         // Three-bit priority
  localparam int          IAP_CTL_MASK_BIT = 3;
  localparam int          IAP_CTL_LVL_BIT  = 4;         // Level trigger select
  localparam int          IAP_CTL_SPECIAL_NESTED_MODE_BIT = 5;         // Special nested mode

  // EOI, status fields
  localparam int          IAP_EOI_NSPEC_BIT = 15;
  localparam int          IAP_ST_IF_BIT     = 0;
  localparam int          IAP_ST_LAT_BIT    = 1;        // Write one to clear
  localparam int          IAP_ST_REQ_BIT    = 2;

  // Reset values
  localparam logic [2:0]  IAP_PRIO_RST = 3'h7;
  localparam logic        IAP_MASK_RST = 1'b1;
  localparam logic [2:0]  IAP_PLIM_RST = 3'h7;

  // Timing: worst accepted latency, in core clocks
  localparam int          IAP_LATENCY_CYCLES = 69;

  // Vector types
  localparam logic [7:0]  IAP_VEC_STEP = 8'h01;
  localparam logic [7:0]  IAP_VEC_NMI  = 8'h02;
  localparam logic [IAP_NPER-1:0][7:0] IAP_PER_VEC =
    {8'h15, 8'h14, 8'h13, 8'h12, 8'h08};               // Tmr0..2, rx, tx from index 0
  localparam logic [IAP_NEXT-1:0][7:0] IAP_EXT_VEC =
    {8'h10, 8'h0f, 8'h0e, 8'h0d, 8'h0c};               // Pin 0 from index 0

  // Kind of vectoring sequence started
  typedef enum logic [1:0] {
    IAP_K_STEP,
    IAP_K_NMI,
    IAP_K_SW,
    IAP_K_MASKABLE
  } iap_kind_e;

endpackage

//--- core/iap_prioritizer.sv
// Maskable interrupt collector, prioritizer and core acceptance gate
`timescale 1ns/1ps

module iap_prioritizer
  import iap_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  // Request sources
  input  wire logic [IAP_NEXT-1:0] external_request_pins,
  input  wire logic [IAP_NPER-1:0] periph_req,
  // Core execution state
  input  wire logic                instr_boundary,
  input  wire logic                prefix_active,
  input  wire logic                seg_reg_load,
  input  wire logic                wait_suspended,
  input  wire logic                string_iter_boundary,
  input  wire logic                numerics_established,
  input  wire logic                refresh_cycle,
  input  wire logic                bus_hold_granted,
  input  wire logic                set_enable_flag_instr,
  input  wire logic                clear_enable_flag_instr,
  input  wire logic                interrupt_return_instr,
  input  wire logic                restored_enable_flag,
  input  wire logic                nmi_pin,
  input  wire logic                sw_trap_req,
  input  wire logic [7:0]          sw_trap_type,
  input  wire logic                single_step_flag,
  // Core vectoring outputs
  output logic                     core_intr_req,
  output logic                     vector_start,
  output logic [7:0]               vector_type,
  output logic [1:0]               vector_kind,
  output logic                     return_to_wait,
  output logic                     restore_last_prefix_only,
  output logic                     step_suppress,
  output logic                     enable_flag,
  output logic                     latency_overrun
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [IAP_NGRP-1:0][2:0] prio;            // Priority per group
  logic [IAP_NGRP-1:0]      mask_bits;       // Shared by mask and control regs
  logic [IAP_NEXT-1:0]      lvl_sel;         // Level trigger per pin
  logic [1:0]               special_nested_mode;            // Special nested, pins 0 and 1
  logic [2:0]               plim;            // Priority limit
  logic [IAP_NGRP-1:0]      insrv;           // In-service bits
  logic [IAP_NPER-1:0]      per_pend;        // Latched peripheral requests
  logic [IAP_NEXT-1:0]      ext_prev;        // Pin level one clock ago
  logic [IAP_NEXT-1:0]      ext_armed;       // Rising edge seen, pin still high
  logic                     nmi_prev;        // NMI pin one clock ago
  logic                     nmi_pend;        // Latched NMI edge
  logic                     sw_pend;         // Pending software trap
  logic [7:0]               sw_type_q;       // Its vector type
  logic                     seg_shadow;      // One-instruction deferral
  logic [1:0]               step_hold;       // Returns left before stepping
  logic [6:0]               lat_cnt;         // Cycles the request has waited

  ////////////////////////////////////////////////////////////////////////////
  // Combinational arbitration
  logic [IAP_NGRP-1:0]      grp_req;         // Raw request per group
  logic [IAP_NEXT-1:0]      ext_req;         // Pin requests, unlatched
  logic [IAP_NGRP-1:0]      elig;            // Enabled and allowed to nest
  logic                     isr_any;
  logic [2:0]               isr_min;         // Best in-service priority
  logic [2:0]               isr_top;         // Group holding it
  logic                     win_vld;
  logic [2:0]               win_grp;
  logic [2:0]               win_prio;
  logic [7:0]               win_vec;
  logic [IAP_NPER-1:0]      per_take;        // Peripheral line being served
  logic                     accept_pt;       // Core may vector now
  logic                     bus_free;
  logic                     step_req;
  logic                     take_step;
  logic                     take_nmi;
  logic                     take_sw;
  logic                     take_mask;
  logic                     take_any;
  logic                     all_three;
  logic                     mask_ok;
  logic [IAP_NGRP-1:0]      lvl_grp;         // Level select at group positions
  logic [IAP_NGRP-1:0]      special_nested_mode_grp;        // Special nested at group positions

  // Pin request forms, per pin
  genvar gp;
  generate
    for (gp = 0; gp < IAP_NEXT; gp++) begin : g_pin
      // Level mode: high alone requests; edge mode needs the armed edge
      assign ext_req[gp] = external_request_pins[gp] &
                           (lvl_sel[gp] | ext_armed[gp]);
      assign grp_req[IAP_G_EXT0+gp] = ext_req[gp];
    end
  endgenerate

  assign grp_req[IAP_G_TMR] = |per_pend[2:0];
  assign grp_req[IAP_G_SER] = |per_pend[4:3];

  // Pin-only bits spread over groups, zero for timers and serial
  assign lvl_grp  = {lvl_sel, {IAP_G_EXT0{1'b0}}};
  assign special_nested_mode_grp = {{(IAP_NEXT-2){1'b0}}, special_nested_mode, {IAP_G_EXT0{1'b0}}};

  // In-service summary for nesting
  always_comb begin
    isr_any = 1'b0;
    isr_min = 3'h7;
    isr_top = 3'h0;
    for (int g = 0; g < IAP_NGRP; g++) begin
      if (insrv[g] && (!isr_any || prio[g] < isr_min)) begin
        isr_any = 1'b1;
        isr_min = prio[g];
        isr_top = 3'(g);
      end
    end
  end

  // Eligibility and winner selection
  always_comb begin
    logic own_ok;
    logic lvl_ok;
    own_ok   = 1'b0;
    lvl_ok   = 1'b0;
    win_vld  = 1'b0;
    win_grp  = 3'h0;
    win_prio = 3'h7;
    for (int g = 0; g < IAP_NGRP; g++) begin
      // Own in-service bit blocks unless special nested on pins 0-1
      own_ok = !insrv[g] || special_nested_mode_grp[g];
      lvl_ok = !isr_any || prio[g] < isr_min ||
               (insrv[g] && own_ok && prio[g] == isr_min);
      elig[g] = grp_req[g] && !mask_bits[g] &&
                prio[g] <= plim && own_ok && lvl_ok;
      // Strictly better priority wins; ties keep lower group index
      if (elig[g] && (!win_vld || prio[g] < win_prio)) begin
        win_vld  = 1'b1;
        win_grp  = 3'(g);
        win_prio = prio[g];
      end
    end
  end

  // Vector and served line of the winning group
  always_comb begin
    per_take = '0;
    win_vec  = 8'h00;
    if (win_grp == IAP_G_TMR) begin
      // Lowest-numbered pending timer goes first
      if (per_pend[0]) begin
        per_take[0] = 1'b1;
        win_vec     = IAP_PER_VEC[0];
      end else if (per_pend[1]) begin
        per_take[1] = 1'b1;
        win_vec     = IAP_PER_VEC[1];
      end else begin
        per_take[2] = 1'b1;
        win_vec     = IAP_PER_VEC[2];
      end
    end else if (win_grp == IAP_G_SER) begin
      if (per_pend[3]) begin
        per_take[3] = 1'b1;
        win_vec     = IAP_PER_VEC[3];
      end else begin
        per_take[4] = 1'b1;
        win_vec     = IAP_PER_VEC[4];
      end
    end else begin
      win_vec = IAP_EXT_VEC[win_grp - 3'(IAP_G_EXT0)];
    end
  end

  // Presented only while a live winner exists: no fallback vector
  assign core_intr_req = win_vld;

  ////////////////////////////////////////////////////////////////////////////
  // Core acceptance gate
  // Prefixes belong to the next instruction, so a prefix boundary is no point
  assign accept_pt = (instr_boundary && !prefix_active) ||
                     string_iter_boundary ||
                     wait_suspended;
  assign bus_free  = !refresh_cycle && !bus_hold_granted;
  assign step_req  = instr_boundary && !prefix_active &&
                     single_step_flag && !step_suppress;
  assign all_three = step_req && nmi_pend && sw_pend;

  // Maskable path: enable flag, segment shadow and numerics all gate it
  assign mask_ok   = win_vld && enable_flag &&
                     !seg_shadow && !seg_reg_load &&
                     !numerics_established;

  // Nonmaskable ones ignore every mask
  always_comb begin
    take_step = 1'b0;
    take_nmi  = 1'b0;
    take_sw   = 1'b0;
    take_mask = 1'b0;
    if (accept_pt && bus_free) begin
      if (all_three) begin
        take_sw = 1'b1;
      end else if (step_req) begin
        take_step = 1'b1;
      end else if (nmi_pend) begin
        take_nmi = 1'b1;
      end else if (sw_pend) begin
        take_sw = 1'b1;
      end else if (mask_ok) begin
        take_mask = 1'b1;
      end
    end
  end
  assign take_any = take_step | take_nmi | take_sw | take_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Vectoring outputs, registered one clock after acceptance
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vector_start             <= 1'b0;
      vector_type              <= 8'h00;
      vector_kind              <= IAP_K_STEP;
      return_to_wait           <= 1'b0;
      restore_last_prefix_only <= 1'b0;
    end else begin
      vector_start             <= take_any;
      return_to_wait           <= take_any && wait_suspended;
      restore_last_prefix_only <= take_any && string_iter_boundary;
      if (take_step) begin
        vector_type <= IAP_VEC_STEP;
        vector_kind <= IAP_K_STEP;
      end else if (take_nmi) begin
        vector_type <= IAP_VEC_NMI;
        vector_kind <= IAP_K_NMI;
      end else if (take_sw) begin
        vector_type <= sw_type_q;
        vector_kind <= IAP_K_SW;
      end else if (take_mask) begin
        vector_type <= win_vec;
        vector_kind <= IAP_K_MASKABLE;
      end
    end
  end

  // Interrupt enable flag; vectoring clears and wins over instructions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_flag <= 1'b0;
    end else if (take_any) begin
      enable_flag <= 1'b0;
    end else if (interrupt_return_instr) begin
      enable_flag <= restored_enable_flag;
    end else if (set_enable_flag_instr) begin
      enable_flag <= 1'b1;
    end else if (clear_enable_flag_instr) begin
      enable_flag <= 1'b0;
    end
  end

  // Segment load shadow: cleared by the following instruction boundary
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seg_shadow <= 1'b0;
    end else if (instr_boundary && !prefix_active) begin
      seg_shadow <= seg_reg_load;
    end
  end

  // Step suppression across the software and NMI routines
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_hold     <= 2'h0;
      step_suppress <= 1'b0;
    end else if (take_sw && all_three) begin
      step_hold     <= 2'h2;
      step_suppress <= 1'b1;
    end else if (interrupt_return_instr && step_suppress) begin
      // Stepping resumes once both routines have returned
      step_hold     <= step_hold - 2'h1;
      step_suppress <= (step_hold != 2'h1);
    end
  end

  // NMI edge latch and pending software trap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nmi_prev  <= 1'b0;
      nmi_pend  <= 1'b0;
      sw_pend   <= 1'b0;
      sw_type_q <= 8'h00;
    end else begin
      nmi_prev <= nmi_pin;
      // A new edge wins over the clear of the one being served
      if (nmi_pin && !nmi_prev) begin
        nmi_pend <= 1'b1;
      end else if (take_nmi) begin
        nmi_pend <= 1'b0;
      end
      if (sw_trap_req) begin
        sw_pend   <= 1'b1;
        sw_type_q <= sw_trap_type;
      end else if (take_sw) begin
        sw_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request capture
  // Peripheral lines are sticky until served; a new pulse beats the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      per_pend <= '0;
    end else begin
      per_pend <= periph_req |
                  (per_pend & ~(take_mask ? per_take : '0));
    end
  end

  // Pin edge arming: needs one low clock, drops as soon as the pin falls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_prev  <= '1;          // Pin high at reset is not an edge
      ext_armed <= '0;
    end else begin
      ext_prev <= external_request_pins;
      for (int p = 0; p < IAP_NEXT; p++) begin
        if (!external_request_pins[p]) begin
          ext_armed[p] <= 1'b0;
        end else if (!ext_prev[p]) begin
          ext_armed[p] <= 1'b1;
        end else if (take_mask && win_grp == 3'(IAP_G_EXT0 + p)) begin
          ext_armed[p] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // In-service bits: set on acknowledge, cleared by end-of-interrupt
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      insrv <= '0;
    end else begin
      for (int g = 0; g < IAP_NGRP; g++) begin
        if (take_mask && win_grp == 3'(g)) begin
          insrv[g] <= 1'b1;
        end else if (reg_wr && reg_addr == IAP_OFS_EOI) begin
          if (reg_wdata[IAP_EOI_NSPEC_BIT]) begin
            // Nonspecific: retire the best in-service source
            if (isr_any && isr_top == 3'(g)) begin
              insrv[g] <= 1'b0;
            end
          end else if (reg_wdata[2:0] == 3'(g)) begin
            insrv[g] <= 1'b0;
          end
        end
      end
    end
  end

  // Latency watchdog while the core leaves a request waiting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lat_cnt         <= 7'h00;
      latency_overrun <= 1'b0;
    end else begin
      if (!win_vld || !enable_flag || take_any) begin
        lat_cnt <= 7'h00;
      end else if (lat_cnt != 7'(IAP_LATENCY_CYCLES)) begin
        lat_cnt <= lat_cnt + 7'h01;
      end
      // New overrun wins over a software clear
      if (lat_cnt == 7'(IAP_LATENCY_CYCLES) && win_vld && enable_flag) begin
        latency_overrun <= 1'b1;
      end else if (reg_wr && reg_addr == IAP_OFS_STATUS &&
                   reg_wdata[IAP_ST_LAT_BIT]) begin
        latency_overrun <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes: control registers and mask register share mask bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prio      <= {IAP_NGRP{IAP_PRIO_RST}};
      mask_bits <= {IAP_NGRP{IAP_MASK_RST}};
      lvl_sel   <= '0;
      special_nested_mode      <= '0;
      plim      <= IAP_PLIM_RST;
    end else if (reg_wr) begin
      if (reg_addr == IAP_OFS_MASK) begin
        mask_bits <= reg_wdata[IAP_NGRP-1:0];
      end
      if (reg_addr == IAP_OFS_PLIM) begin
        plim <= reg_wdata[2:0];
      end
      for (int g = 0; g < IAP_NGRP; g++) begin
        if (reg_addr == IAP_OFS_CTL0 + 8'(g) * IAP_CTL_STRIDE) begin
          prio[g]      <= reg_wdata[IAP_CTL_PRIO_LSB +: 3];
          mask_bits[g] <= reg_wdata[IAP_CTL_MASK_BIT];
        end
      end
      // Pin-only fields walked per pin, so no index runs below zero
      for (int p = 0; p < IAP_NEXT; p++) begin
        if (reg_addr == IAP_OFS_CTL0 + 8'(IAP_G_EXT0 + p) * IAP_CTL_STRIDE) begin
          lvl_sel[p] <= reg_wdata[IAP_CTL_LVL_BIT];
        end
      end
      for (int s = 0; s < 2; s++) begin
        if (reg_addr == IAP_OFS_CTL0 + 8'(IAP_G_EXT0 + s) * IAP_CTL_STRIDE) begin
          special_nested_mode[s] <= reg_wdata[IAP_CTL_SPECIAL_NESTED_MODE_BIT];
        end
      end
    end
  end

  // Register reads: data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;                                         // Unmapped reads zero
      if (reg_rd) begin
        unique case (reg_addr)
          IAP_OFS_MASK:   reg_rdata[IAP_NGRP-1:0] <= mask_bits;
          IAP_OFS_PLIM:   reg_rdata[2:0]          <= plim;
          IAP_OFS_INSERV: reg_rdata[IAP_NGRP-1:0] <= insrv;
          IAP_OFS_REQST:  reg_rdata[IAP_NGRP-1:0] <= grp_req;
          IAP_OFS_STATUS: begin
            reg_rdata[IAP_ST_IF_BIT]  <= enable_flag;
            reg_rdata[IAP_ST_LAT_BIT] <= latency_overrun;
            reg_rdata[IAP_ST_REQ_BIT] <= win_vld;
          end
          default: begin
            for (int g = 0; g < IAP_NGRP; g++) begin
              if (reg_addr == IAP_OFS_CTL0 + 8'(g) * IAP_CTL_STRIDE) begin
                reg_rdata[IAP_CTL_PRIO_LSB +: 3] <= prio[g];
                reg_rdata[IAP_CTL_MASK_BIT]      <= mask_bits[g];
                reg_rdata[IAP_CTL_LVL_BIT]       <= lvl_grp[g];
                reg_rdata[IAP_CTL_SPECIAL_NESTED_MODE_BIT]      <= special_nested_mode_grp[g];
              end
            end
          end
        endcase
      end
    end
  end

endmodule // iap_prioritizer

//--- verification/iap_props.sv
// Port checker bound onto the interrupt accept prioritizer
`timescale 1ns/1ps
module iap_props
  import iap_pkg::*;
(
  input wire logic       clk, sys_rst, instr_boundary, prefix_active, seg_reg_load,
  input wire logic       wait_suspended, string_iter_boundary, numerics_established,
  input wire logic       refresh_cycle, bus_hold_granted, core_intr_req, vector_start,
  input wire logic       enable_flag, return_to_wait, restore_last_prefix_only,
  input wire logic [1:0] vector_kind,
  input wire logic [7:0] vector_type
);
  wire mk = vector_start && vector_kind == 2'h3;  // Maskable vectoring starts
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Prefix boundaries are no accept point
  property p_pfx; instr_boundary && prefix_active && !string_iter_boundary
    && !wait_suspended |=> !vector_start; endproperty
  a_pfx: assert property (p_pfx) else $error("vectored at prefix");
  property p_blk; refresh_cycle || bus_hold_granted |=> !vector_start; endproperty
  a_blk: assert property (p_blk) else $error("vectored in refresh or hold");
  property p_num; numerics_established |=> !mk; endproperty
  a_num: assert property (p_num) else $error("vectored in numerics");
  property p_seg; instr_boundary && seg_reg_load |=> !mk; endproperty
  a_seg: assert property (p_seg) else $error("vectored after segment load");
  // Maskable needs flag and a presented request one cycle before
  property p_ief; mk |-> $past(enable_flag) && $past(core_intr_req); endproperty
  a_ief: assert property (p_ief) else $error("maskable without gate");
  property p_clr; mk |-> !enable_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag kept on vectoring");
  property p_wt; return_to_wait |-> vector_start && $past(wait_suspended); endproperty
  a_wt: assert property (p_wt) else $error("bad wait return");
  property p_rp; restore_last_prefix_only |-> vector_start
    && $past(string_iter_boundary); endproperty
  a_rp: assert property (p_rp) else $error("bad prefix restore");
  property p_nmi; vector_start && vector_kind == 2'h1 |-> vector_type == IAP_VEC_NMI;
  endproperty
  a_nmi: assert property (p_nmi) else $error("bad nmi vector");
endmodule // iap_props
bind iap_prioritizer iap_props u_props (.*);

//--- verification/iap_core_model.sv
// Core boundary and pin requester model facing the prioritizer
`timescale 1ns/1ps
module iap_core_model (
  input  wire logic       clk,
  input  wire logic       run,           // Core executing
  input  wire logic [4:0] raise,         // Requesters wanting service
  input  wire logic       vector_start,
  output logic            instr_boundary,
  output logic [4:0]      pins
);
  logic [1:0] cnt;                       // Instruction length
  initial begin
    cnt = 2'h0;
    pins = 5'h00;
    instr_boundary = 1'b0;
  end
  // Every fourth clock an instruction ends
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    instr_boundary <= run && cnt == 2'h3;
  end
  // Pins rise from low and hold until vectoring; a dropped pin would be lost
  always @(posedge clk) begin
    pins <= vector_start ? 5'h00 : pins | raise;
  end
endmodule // iap_core_model

//--- verification/testbench.sv
// Self-checking bench for the interrupt accept prioritizer
`timescale 1ns/1ps
module testbench import iap_pkg::*;;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
  logic [7:0] reg_addr = 8'h00, sw_trap_type = 8'h00, vector_type;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [4:0] pins, raise = 5'h00, periph_req = 5'h00;
  logic prefix_active = 0, seg_reg_load = 0, wait_suspended = 0, string_iter_boundary = 0;
  logic numerics_established = 0, refresh_cycle = 0, bus_hold_granted = 0, nmi_pin = 0;
  logic set_enable_flag_instr = 0, clear_enable_flag_instr = 0, interrupt_return_instr = 0;
  logic restored_enable_flag = 0, sw_trap_req = 0, single_step_flag = 0, instr_boundary;
  logic core_intr_req, vector_start, return_to_wait, restore_last_prefix_only;
  logic step_suppress, enable_flag, latency_overrun;
  logic [1:0] vector_kind;
  int err_total = 0, n_compared = 0;
  iap_prioritizer dut (.*, .external_request_pins(pins));
  iap_core_model u_core (.clk(clk), .run(run), .raise(raise), .vector_start(vector_start),
    .instr_boundary(instr_boundary), .pins(pins));
  initial forever #4 clk = ~clk;
  //////////////////////////////////////////
  task chk(input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("Error %0t: seen %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) chk(reg_rdata, e);
  endtask
  task sef;
    @(posedge clk) set_enable_flag_instr <= 1'b1;
    @(posedge clk) set_enable_flag_instr <= 1'b0;
  endtask
  // Bounded wait for vectoring, then type and kind
  task wv(input logic [7:0] t, input logic [1:0] k);
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      if (vector_start === 1'b1) break;
    end
    chk({5'h00, vector_start, vector_kind, vector_type}, {5'h00, 1'b1, k, t});
  endtask
  //////////////////////////////////////////
  task t_pin;
    wr(8'h16, 16'h0000);
    sef();
    run <= 1'b1;
    // Each blocker held in turn: nothing may vector
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) {refresh_cycle, bus_hold_granted, numerics_established, prefix_active,
        seg_reg_load, raise} <= {5'h10 >> i, 5'h01};
      repeat (16) @(negedge clk);
      chk(enable_flag, 1'b1);
    end
    @(posedge clk) {refresh_cycle, bus_hold_granted, numerics_established, prefix_active,
      seg_reg_load, raise} <= 10'h000;
    wv(8'h0c, 2'h3);
    chk(enable_flag, 1'b0);
    rd(IAP_OFS_INSERV, 16'h0004);
    wr(IAP_OFS_EOI, 16'h8000);
    rd(IAP_OFS_INSERV, 16'h0000);
    chk(latency_overrun, 1'b1);
    rd(IAP_OFS_STATUS, 16'h0002);
    wr(IAP_OFS_STATUS, 16'h0002);
  endtask
  // Timer pulse survives a limit block in the latch
  task t_per;
    wr(8'h12, 16'h0001);
    wr(IAP_OFS_PLIM, 16'h0000);
    @(posedge clk) periph_req <= 5'h01;
    @(posedge clk) periph_req <= 5'h00;
    repeat (3) @(negedge clk);
    chk(core_intr_req, 1'b0);
    wr(IAP_OFS_PLIM, 16'h0001);
    @(negedge clk) chk(core_intr_req, 1'b1);
    sef();
    wv(8'h08, 2'h3);
    rd(IAP_OFS_STATUS, 16'h0000);
  endtask
  // Special nested pin re-enters while its own in-service bit stands
  task t_sfn;
    wr(8'h16, 16'h0020);
    sef();
    @(posedge clk) raise <= 5'h01;
    wv(8'h0c, 2'h3);
    sef();
    wv(8'h0c, 2'h3);
    @(posedge clk) raise <= 5'h00;
    rd(IAP_OFS_INSERV, 16'h0005);
  endtask
  // Traps alone, then step, nmi and software pending together
  task t_trp;
    @(posedge clk) nmi_pin <= 1'b1;
    wv(IAP_VEC_NMI, 2'h1);
    @(posedge clk) {sw_trap_req, sw_trap_type} <= {1'b1, 8'h21};
    @(posedge clk) sw_trap_req <= 1'b0;
    wv(8'h21, 2'h2);
    @(posedge clk) {run, nmi_pin} <= 2'b00;
    @(posedge clk) {nmi_pin, single_step_flag, sw_trap_req, sw_trap_type} <= {3'b111, 8'h22};
    @(posedge clk) {run, sw_trap_req} <= 2'b10;
    wv(8'h22, 2'h2);
    chk(step_suppress, 1'b1);
    wv(IAP_VEC_NMI, 2'h1);
    @(posedge clk) interrupt_return_instr <= 1'b1;
    repeat (2) @(posedge clk);
    interrupt_return_instr <= 1'b0;
    wv(IAP_VEC_STEP, 2'h0);
    chk(step_suppress, 1'b0);
  endtask
  // Wait-suspended and string-iteration accept points
  task t_acc;
    @(posedge clk) {run, single_step_flag, sw_trap_req, sw_trap_type} <= {3'b001, 8'h23};
    @(posedge clk) {sw_trap_req, wait_suspended} <= 2'b01;
    wv(8'h23, 2'h2);
    chk(return_to_wait, 1'b1);
    @(posedge clk) {wait_suspended, sw_trap_req, sw_trap_type} <= {2'b01, 8'h24};
    @(posedge clk) {sw_trap_req, string_iter_boundary} <= 2'b01;
    @(posedge clk) string_iter_boundary <= 1'b0;
    wv(8'h24, 2'h2);
    chk(restore_last_prefix_only, 1'b1);
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000 err_total++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(IAP_OFS_MASK, 16'h007f);
    rd(IAP_OFS_PLIM, 16'h0007);
    rd(8'h12, 16'h000f);
    rd(8'h40, 16'h0000);
    t_pin();
    t_per();
    t_sfn();
    t_trp();
    t_acc();
    conclude();
  end
endmodule // testbench
